/* File: core/rfq_defs.vh */
// Register offsets, field positions, reset values and codes of the transfer queue block
`ifndef RFQ_DEFS_VH
`define RFQ_DEFS_VH

`define RFQ_ADDR_W 6
`define RFQ_OFS_STATUS 6'h08
`define RFQ_OFS_DATA 6'h09
`define RFQ_OFS_LEVEL 6'h0a
`define RFQ_OFS_THRESH 6'h0b

`define RFQ_ST_OTCLR_BIT 7
`define RFQ_ST_FORCE_BIT 6
`define RFQ_ST_CIPHER_BIT 3
`define RFQ_LVL_FLUSH_BIT 7
`define RFQ_STATUS_RESET 8'h00
`define RFQ_LEVEL_RESET 8'h00

`define RFQ_DEPTH 64
`define RFQ_PTR_W 6
`define RFQ_CNT_W 7
`define RFQ_THRESH_W 6
`define RFQ_THRESH_RESET 6'h08

`define RFQ_ALARM_DEGC 125

`define RFQ_GUARD_W 8

`define RFQ_LS_IDLE 3'h0
`define RFQ_LS_WAIT_TRIG 3'h1
`define RFQ_LS_TX_GUARD 3'h2
`define RFQ_LS_TX 3'h3
`define RFQ_LS_RX_GUARD 3'h4
`define RFQ_LS_WAIT_DATA 3'h5
`define RFQ_LS_RX 3'h6

`endif

/* File: core/rfq_skid.v */
// Two-entry buffer with valid and ready on both sides
module rfq_skid #(
   parameter WIDTH = 8
) (
   // Clock and reset
   input wire sys_clk,
   input wire rst,
   // Filling side
   input wire in_valid,
   input wire [WIDTH-1:0] in_data,
   output wire in_ready,
   // Draining side
   output wire out_valid,
   output wire [WIDTH-1:0] out_data,
   input wire out_ready
);
   reg [WIDTH-1:0] slot0_reg;
   reg [WIDTH-1:0] slot1_reg;
   reg [1:0] cnt_reg;
   wire take;
   wire give;

   assign in_ready = (cnt_reg != 2'h2);
   assign out_valid = (cnt_reg != 2'h0);
   assign out_data = slot0_reg;
   assign take = in_valid & in_ready;
   assign give = out_valid & out_ready;

   always @(posedge sys_clk)
   begin
      if (rst)
      begin
         slot0_reg <= {WIDTH{1'b0}};
         slot1_reg <= {WIDTH{1'b0}};
         cnt_reg <= 2'h0;
      end
      else
      begin
         // Slot 0 always holds the oldest word
         if (give)
         begin
            if (cnt_reg == 2'h2)
               slot0_reg <= slot1_reg;
            else if (take)
               slot0_reg <= in_data;
         end
         else if (take && cnt_reg == 2'h0)
            slot0_reg <= in_data;
         if (take && ((cnt_reg == 2'h1 && !give) || (cnt_reg == 2'h2 && give)))
            slot1_reg <= in_data;
         if (take && !give)
            cnt_reg <= cnt_reg + 2'h1;
         else if (give && !take)
            cnt_reg <= cnt_reg - 2'h1;
      end
   end
endmodule

/* File: core/rfq_store.v */
// 64-byte first-in first-out byte store with fill count and flush
`include "rfq_defs.vh"

module rfq_store #(
   parameter DEPTH = `RFQ_DEPTH,
   parameter PTR_W = `RFQ_PTR_W,
   parameter CNT_W = `RFQ_CNT_W
) (
   // Clock and reset
   input wire sys_clk,
   input wire rst,
   // Control
   input wire flush,
   input wire push,
   input wire [7:0] push_data,
   input wire pop,
   // State
   output wire [7:0] head_data,
   output wire [CNT_W-1:0] count,
   output wire full,
   output wire empty
);
   reg [7:0] mem [0:DEPTH-1];
   reg [PTR_W-1:0] wr_ptr_reg;
   reg [PTR_W-1:0] rd_ptr_reg;
   reg [CNT_W-1:0] count_reg;
   wire do_push;
   wire do_pop;

   localparam [CNT_W-1:0] DEPTH_C = DEPTH;

   assign full = (count_reg == DEPTH_C);
   assign empty = (count_reg == {CNT_W{1'b0}});
   assign count = count_reg;
   assign head_data = mem[rd_ptr_reg];
   // Full push and empty pop leave everything untouched
   assign do_push = push & ~full & ~flush;
   assign do_pop = pop & ~empty & ~flush;

   always @(posedge sys_clk)
   begin
      if (do_push)
         mem[wr_ptr_reg] <= push_data;
   end

   always @(posedge sys_clk)
   begin
      if (rst || flush)
      begin
         wr_ptr_reg <= {PTR_W{1'b0}};
         rd_ptr_reg <= {PTR_W{1'b0}};
         count_reg <= {CNT_W{1'b0}};
      end
      else
      begin
         if (do_push)
            wr_ptr_reg <= wr_ptr_reg + {{(PTR_W-1){1'b0}}, 1'b1};
         if (do_pop)
            rd_ptr_reg <= rd_ptr_reg + {{(PTR_W-1){1'b0}}, 1'b1};
         if (do_push && !do_pop)
            count_reg <= count_reg + {{(CNT_W-1){1'b0}}, 1'b1};
         else if (do_pop && !do_push)
            count_reg <= count_reg - {{(CNT_W-1){1'b0}}, 1'b1};
      end
   end
endmodule

/* File: core/rfq_top.v */
// Transfer queue, fill level, warning threshold and link status register block
//
// Overview of operation
// - 64-byte queue, data port pushes and pops
// - Queue stages every serial stream in and out
// - Seven-bit fill count tracks pushes and pops
// - Flush resets pointers; clears overflow unless an engine push hits the full queue
// - Flush bit always reads back zero
// - Near-full when free space within threshold
// - Near-empty when held bytes within threshold
// - Six-bit threshold, read-write, resets to eight
// - Overtemp clear works only below alarm limit
// - Force bit selects high-speed input filter
// - Cipher flag set only by authentication success
// - Only software clears cipher flag; encrypt meanwhile
// - State codes for idle, trigger, transmit, receive
// - Code 010 during transmit guard wait
// - Code 100 during receive guard wait
// - Push into full queue sets overflow flag
`include "rfq_defs.vh"

module rfq_top #(
   parameter DEPTH = `RFQ_DEPTH,
   parameter GUARD_W = `RFQ_GUARD_W
) (
   // Clock and reset
   input wire sys_clk,
   input wire rst,
   // Register access
   input wire [`RFQ_ADDR_W-1:0] reg_addr,
   input wire reg_wr_stb,
   input wire reg_rd_stb,
   input wire [7:0] reg_wdata,
   output reg [7:0] reg_rdata,
   output reg reg_rd_ack,
   // Receiver side byte pushes
   input wire eng_push_valid,
   input wire [7:0] eng_push_data,
   output wire eng_push_ready,
   // Transmitter side byte pops
   input wire eng_pop_req,
   output reg [7:0] eng_pop_data,
   output reg eng_pop_ack,
   // Queue status
   output wire [`RFQ_CNT_W-1:0] queue_fill_count,
   output wire near_full_alert,
   output wire near_empty_alert,
   output wire queue_overflow_error,
   // Temperature
   input wire overtemp_alarm,
   output wire overtemp_error,
   // Host serial input filter
   input wire proto_highspeed,
   output wire filter_highspeed_sel,
   // Cipher
   input wire auth_success,
   output wire cipher_active,
   // Link sequencing
   input wire cmd_transceive,
   input wire cmd_abort,
   input wire transmit_trigger,
   input wire tx_wait_field,
   input wire [GUARD_W-1:0] tx_guard_cycles,
   input wire [GUARD_W-1:0] rx_guard_cycles,
   input wire rf_field_present,
   input wire tx_done,
   input wire rx_sof,
   input wire rx_done,
   output wire [2:0] link_fsm_state
);
   localparam CNT_W = `RFQ_CNT_W;
   localparam [CNT_W-1:0] DEPTH_C = DEPTH;

   // Register decode
   wire sel_status;
   wire sel_data;
   wire sel_level;
   wire sel_thresh;
   wire wr_status;
   wire wr_data;
   wire rd_data;
   wire wr_level;
   wire wr_thresh;

   assign sel_status = (reg_addr == `RFQ_OFS_STATUS);
   assign sel_data = (reg_addr == `RFQ_OFS_DATA);
   assign sel_level = (reg_addr == `RFQ_OFS_LEVEL);
   assign sel_thresh = (reg_addr == `RFQ_OFS_THRESH);
   assign wr_status = reg_wr_stb & sel_status;
   assign wr_data = reg_wr_stb & sel_data;
   assign rd_data = reg_rd_stb & sel_data;
   assign wr_level = reg_wr_stb & sel_level;
   assign wr_thresh = reg_wr_stb & sel_thresh;

   // Pin input synchronisers
   reg alarm_meta_reg;
   reg alarm_sync_reg;
   reg field_meta_reg;
   reg field_sync_reg;

   always @(posedge sys_clk)
   begin
      if (rst)
      begin
         alarm_meta_reg <= 1'b0;
         alarm_sync_reg <= 1'b0;
         field_meta_reg <= 1'b0;
         field_sync_reg <= 1'b0;
      end
      else
      begin
         alarm_meta_reg <= overtemp_alarm;
         alarm_sync_reg <= alarm_meta_reg;
         field_meta_reg <= rf_field_present;
         field_sync_reg <= field_meta_reg;
      end
   end

   // Queue and receiver-side buffer
   wire [7:0] head_data;
   wire [CNT_W-1:0] count;
   wire full;
   wire empty;
   wire skid_valid;
   wire [7:0] skid_data;
   wire skid_ready;
   wire host_push;
   wire eng_push;
   wire store_push;
   wire [7:0] store_push_data;
   wire host_pop;
   wire eng_pop;
   wire flush;

   rfq_skid #(
      .WIDTH(8)
   ) rfq_skid_i (
      .sys_clk(sys_clk),
      .rst(rst),
      .in_valid(eng_push_valid),
      .in_data(eng_push_data),
      .in_ready(eng_push_ready),
      .out_valid(skid_valid),
      .out_data(skid_data),
      .out_ready(skid_ready)
   );

   assign host_push = wr_data;
   // engine bytes wait while host pushes
   assign skid_ready = ~host_push;
   assign eng_push = skid_valid & skid_ready;
   assign store_push = host_push | eng_push;
   assign store_push_data = host_push ? reg_wdata : skid_data;
   assign host_pop = rd_data;
   // transmitter pops when host is not reading
   assign eng_pop = eng_pop_req & ~host_pop & ~empty;
   assign flush = wr_level & reg_wdata[`RFQ_LVL_FLUSH_BIT];

   // guarded push and pop inside store
   rfq_store #(
      .DEPTH(DEPTH),
      .PTR_W(`RFQ_PTR_W),
      .CNT_W(CNT_W)
   ) rfq_store_i (
      .sys_clk(sys_clk),
      .rst(rst),
      .flush(flush),
      .push(store_push),
      .push_data(store_push_data),
      .pop(host_pop | eng_pop),
      .head_data(head_data),
      .count(count),
      .full(full),
      .empty(empty)
   );

   assign queue_fill_count = count;

   // Overflow flag
   reg overflow_reg;

   always @(posedge sys_clk)
   begin
      if (rst)
         overflow_reg <= 1'b0;
      else if (store_push && full)
         overflow_reg <= 1'b1;
      else if (flush)
         overflow_reg <= 1'b0;
   end

   assign queue_overflow_error = overflow_reg;

   // Warning threshold and alerts
   reg [`RFQ_THRESH_W-1:0] thresh_reg;
   wire [CNT_W-1:0] free_space;
   wire [CNT_W-1:0] thresh_wide;

   always @(posedge sys_clk)
   begin
      if (rst)
         thresh_reg <= `RFQ_THRESH_RESET;
      else if (wr_thresh)
         thresh_reg <= reg_wdata[`RFQ_THRESH_W-1:0];
   end

   assign free_space = DEPTH_C - count;
   assign thresh_wide = {1'b0, thresh_reg};
   assign near_full_alert = (free_space <= thresh_wide);
   assign near_empty_alert = (count <= thresh_wide);

   // Status register bits
   reg otclr_reg;
   reg force_reg;
   reg cipher_reg;
   reg overtemp_reg;

   always @(posedge sys_clk)
   begin
      if (rst)
      begin
         otclr_reg <= 1'b0;
         force_reg <= 1'b0;
      end
      else if (wr_status)
      begin
         otclr_reg <= reg_wdata[`RFQ_ST_OTCLR_BIT];
         force_reg <= reg_wdata[`RFQ_ST_FORCE_BIT];
      end
   end

   always @(posedge sys_clk)
   begin
      if (rst)
         overtemp_reg <= 1'b0;
      else if (alarm_sync_reg)
         overtemp_reg <= 1'b1;
      else if (wr_status && reg_wdata[`RFQ_ST_OTCLR_BIT])
         overtemp_reg <= 1'b0;
   end

   assign overtemp_error = overtemp_reg;
   assign filter_highspeed_sel = force_reg | proto_highspeed;

   always @(posedge sys_clk)
   begin
      if (rst)
         cipher_reg <= 1'b0;
      else if (auth_success)
         cipher_reg <= 1'b1;
      else if (wr_status && !reg_wdata[`RFQ_ST_CIPHER_BIT])
         cipher_reg <= 1'b0;
   end

   assign cipher_active = cipher_reg;

   // Link state machine
   reg [2:0] ls_reg;
   reg [2:0] ls_next;
   reg [GUARD_W-1:0] guard_cnt_reg;
   wire field_ok;
   wire tx_guard_done;
   wire rx_guard_done;
   wire guard_max;

   assign field_ok = ~tx_wait_field | field_sync_reg;
   assign guard_max = &guard_cnt_reg;
   assign tx_guard_done = (guard_cnt_reg >= tx_guard_cycles) & field_ok;
   assign rx_guard_done = (guard_cnt_reg >= rx_guard_cycles) & field_ok;

   always @*
   begin
      ls_next = ls_reg;
      if (cmd_abort)
         ls_next = `RFQ_LS_IDLE;
      else
      begin
         case (ls_reg)
            `RFQ_LS_IDLE:
               if (cmd_transceive)
                  ls_next = `RFQ_LS_WAIT_TRIG;
            `RFQ_LS_WAIT_TRIG:
               if (transmit_trigger)
                  ls_next = `RFQ_LS_TX_GUARD;
            `RFQ_LS_TX_GUARD:
               if (tx_guard_done)
                  ls_next = `RFQ_LS_TX;
            `RFQ_LS_TX:
               if (tx_done)
                  ls_next = `RFQ_LS_RX_GUARD;
            `RFQ_LS_RX_GUARD:
               if (rx_guard_done)
                  ls_next = `RFQ_LS_WAIT_DATA;
            `RFQ_LS_WAIT_DATA:
               if (rx_sof)
                  ls_next = `RFQ_LS_RX;
            `RFQ_LS_RX:
               if (rx_done)
                  ls_next = `RFQ_LS_IDLE;
            default:
               ls_next = `RFQ_LS_IDLE;
         endcase
      end
   end

   always @(posedge sys_clk)
   begin
      if (rst)
      begin
         ls_reg <= `RFQ_LS_IDLE;
         guard_cnt_reg <= {GUARD_W{1'b0}};
      end
      else
      begin
         ls_reg <= ls_next;
         // Guard counter restarts on each state change and saturates
         if (ls_next != ls_reg)
            guard_cnt_reg <= {GUARD_W{1'b0}};
         else if (!guard_max)
            guard_cnt_reg <= guard_cnt_reg + {{(GUARD_W-1){1'b0}}, 1'b1};
      end
   end

   assign link_fsm_state = ls_reg;

   // Register read path and transmitter pop data
   always @(posedge sys_clk)
   begin
      if (rst)
      begin
         reg_rdata <= 8'h00;
         reg_rd_ack <= 1'b0;
         eng_pop_data <= 8'h00;
         eng_pop_ack <= 1'b0;
      end
      else
      begin
         reg_rd_ack <= reg_rd_stb;
         eng_pop_ack <= eng_pop;
         if (eng_pop)
            eng_pop_data <= head_data;
         if (reg_rd_stb)
         begin
            if (sel_status)
               reg_rdata <= {otclr_reg, force_reg, 2'b00, cipher_reg, ls_reg};
            else if (sel_data)
               reg_rdata <= empty ? 8'h00 : head_data;
            else if (sel_level)
               reg_rdata <= {1'b0, count};
            else if (sel_thresh)
               reg_rdata <= {2'b00, thresh_reg};
            else
               reg_rdata <= 8'h00;
         end
      end
   end
endmodule

/* File: sim/rfq_top_sva.sv */
// Port assertions for the transfer queue block
`include "rfq_defs.vh"
module rfq_chk (
   // Clock and reset
   input wire sys_clk,
   input wire rst,
   // Register access
   input wire [`RFQ_ADDR_W-1:0] reg_addr,
   input wire reg_wr_stb,
   input wire reg_rd_stb,
   input wire [7:0] reg_wdata,
   input wire [7:0] reg_rdata,
   input wire reg_rd_ack,
   // Status
   input wire [`RFQ_CNT_W-1:0] queue_fill_count,
   input wire near_full_alert,
   input wire near_empty_alert,
   input wire queue_overflow_error,
   input wire proto_highspeed,
   input wire filter_highspeed_sel,
   input wire auth_success,
   input wire cipher_active,
   input wire cmd_abort,
   input wire [2:0] link_fsm_state
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   reg [5:0] thr_reg;
   reg force_reg;
   // Shadow of the written threshold and force bit
   always @(posedge sys_clk)
   begin
      if (rst)
      begin
         thr_reg <= `RFQ_THRESH_RESET;
         force_reg <= 1'b0;
      end
      else if (reg_wr_stb)
      begin
         if (reg_addr == `RFQ_OFS_THRESH) thr_reg <= reg_wdata[5:0];
         if (reg_addr == `RFQ_OFS_STATUS) force_reg <= reg_wdata[6];
      end
   end
   read_ack_a: assert property (reg_rd_ack == $past(reg_rd_stb))
      else $error("read answer not one cycle after strobe");
   near_full_a: assert property (near_full_alert == ((7'h40 - queue_fill_count) <= {1'b0, thr_reg}))
      else $error("near full alert wrong");
   near_empty_a: assert property (near_empty_alert == (queue_fill_count <= {1'b0, thr_reg}))
      else $error("near empty alert wrong");
   thresh_read_a: assert property (reg_rd_stb && reg_addr == `RFQ_OFS_THRESH |=> reg_rdata == {2'h0, thr_reg})
      else $error("threshold read back wrong");
   overflow_set_a: assert property (reg_wr_stb && reg_addr == `RFQ_OFS_DATA && queue_fill_count == 7'h40 |=> queue_overflow_error && queue_fill_count == 7'h40)
      else $error("full push not flagged");
   flush_clear_a: assert property (reg_wr_stb && reg_addr == `RFQ_OFS_LEVEL && reg_wdata[7] |=> queue_fill_count == 7'h00)
      else $error("flush left bytes");
   flush_zero_a: assert property (reg_rd_stb && reg_addr == `RFQ_OFS_LEVEL |=> !reg_rdata[7])
      else $error("flush bit read as one");
   filter_sel_a: assert property (filter_highspeed_sel == (force_reg | proto_highspeed))
      else $error("filter select wrong");
   cipher_set_a: assert property ($rose(cipher_active) |-> $past(auth_success))
      else $error("cipher flag set without authentication");
   abort_idle_a: assert property (cmd_abort |=> link_fsm_state == `RFQ_LS_IDLE)
      else $error("abort did not return to idle");
endmodule
bind rfq_top rfq_chk rfq_chk_i (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
   .reg_wr_stb(reg_wr_stb), .reg_rd_stb(reg_rd_stb), .reg_wdata(reg_wdata),
   .reg_rdata(reg_rdata), .reg_rd_ack(reg_rd_ack), .queue_fill_count(queue_fill_count),
   .near_full_alert(near_full_alert), .near_empty_alert(near_empty_alert),
   .queue_overflow_error(queue_overflow_error), .proto_highspeed(proto_highspeed),
   .filter_highspeed_sel(filter_highspeed_sel), .auth_success(auth_success),
   .cipher_active(cipher_active), .cmd_abort(cmd_abort), .link_fsm_state(link_fsm_state));

/* File: sim/rfq_eng_model.sv */
// Receiver and transmitter engine model at the queue's byte ports
module rfq_eng_model (
   // Clock
   input wire logic sys_clk,
   // Control from bench
   input wire logic [3:0] push_n,
   input wire logic pop_en,
   // Push side
   output logic push_valid,
   output logic [7:0] push_data,
   input wire logic push_ready,
   // Pop side
   output logic pop_req,
   input wire logic pop_ack,
   input wire logic [7:0] pop_data,
   output logic [31:0] got
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] sent = 4'h0;
   int gn = 0;
   always @(posedge sys_clk)
   begin
      if (push_valid && push_ready) sent <= sent + 4'h1;
      if (pop_ack && gn < 4) got[8*gn +: 8] <= pop_data;
      if (pop_ack) gn <= gn + 1;
   end
   // Hold the offer until taken; released data is inverted; pops stall every other cycle
   always @(negedge sys_clk)
   begin
      push_valid <= sent < push_n;
      push_data <= (sent < push_n) ? 8'h10 + {4'h0, sent} : ~push_data;
      pop_req <= pop_en && !pop_req;
   end
endmodule

/* File: sim/rfq_top_bench.sv */
// Self-checking bench of the transfer queue block
`include "rfq_defs.vh"
module rfq_top_bench;
   timeunit 1ns;
   timeprecision 1ns;
`define CHK(n, e, a) begin tests_run++; if ((e) !== (a)) begin failures++; \
   $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
   int failures = 0;
   int tests_run = 0;
   logic sys_clk = 1'b0, rst = 1'b1, reg_wr_stb = 1'b0, reg_rd_stb = 1'b0;
   logic [5:0] reg_addr = 6'h00, evs = 6'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic alarm = 1'b0, proto = 1'b0, auth = 1'b0, wfield = 1'b0, field = 1'b0, pop_en = 1'b0;
   logic [7:0] txg = 8'h03, rxg = 8'h00;
   logic [3:0] push_n = 4'h0;
   wire [7:0] reg_rdata, pop_data, push_data;
   wire [6:0] cnt;
   wire [31:0] got;
   wire [2:0] st;
   wire reg_rd_ack, push_valid, push_ready, pop_req, pop_ack, nfull, nempty, ovf, oterr, fsel, ciph;
   rfq_top rfq_top_i (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr_stb(reg_wr_stb),
      .reg_rd_stb(reg_rd_stb), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rd_ack(reg_rd_ack),
      .eng_push_valid(push_valid), .eng_push_data(push_data), .eng_push_ready(push_ready),
      .eng_pop_req(pop_req), .eng_pop_data(pop_data), .eng_pop_ack(pop_ack), .queue_fill_count(cnt),
      .near_full_alert(nfull), .near_empty_alert(nempty), .queue_overflow_error(ovf),
      .overtemp_alarm(alarm), .overtemp_error(oterr), .proto_highspeed(proto),
      .filter_highspeed_sel(fsel), .auth_success(auth), .cipher_active(ciph),
      .cmd_transceive(evs[4]), .cmd_abort(evs[5]), .transmit_trigger(evs[3]),
      .tx_wait_field(wfield), .tx_guard_cycles(txg), .rx_guard_cycles(rxg),
      .rf_field_present(field), .tx_done(evs[2]), .rx_sof(evs[1]), .rx_done(evs[0]),
      .link_fsm_state(st));
   rfq_eng_model rfq_eng_model_i (.sys_clk(sys_clk), .push_n(push_n), .pop_en(pop_en),
      .push_valid(push_valid), .push_data(push_data), .push_ready(push_ready), .pop_req(pop_req),
      .pop_ack(pop_ack), .pop_data(pop_data), .got(got));
   initial
   begin
      forever #10 sys_clk = ~sys_clk;
   end
   task conclude;
      if (failures == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task wr(input [5:0] a, input [7:0] d);
      @(negedge sys_clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr_stb = 1'b1;
      @(negedge sys_clk);
      reg_wr_stb = 1'b0;
   endtask
   task rchk(input [5:0] a, input [7:0] e);
      @(negedge sys_clk);
      reg_addr = a;
      reg_rd_stb = 1'b1;
      @(negedge sys_clk);
      reg_rd_stb = 1'b0;
      `CHK("read ack", 1'b1, reg_rd_ack)
      `CHK("read data", e, reg_rdata)
   endtask
   task ev(input [5:0] m, input [2:0] s);
      @(negedge sys_clk);
      evs = m;
      @(negedge sys_clk);
      evs = 6'h00;
      `CHK("link state", s, st)
   endtask
   initial
   begin
      #200000;
      failures++;
      conclude();
   end
   initial
   begin
      repeat (6) @(negedge sys_clk);
      rst = 1'b0;
      rchk(`RFQ_OFS_STATUS, 8'h00);
      rchk(`RFQ_OFS_LEVEL, 8'h00);
      rchk(`RFQ_OFS_THRESH, 8'h08);
      wr(`RFQ_OFS_THRESH, 8'hff);
      rchk(`RFQ_OFS_THRESH, 8'h3f);
      wr(`RFQ_OFS_THRESH, 8'h04);
      rchk(6'h3f, 8'h00);
      for (int i = 1; i <= 64; i++)
      begin
         wr(`RFQ_OFS_DATA, i[7:0]);
         `CHK("near full", (64 - i) <= 4, nfull)
         `CHK("near empty", i <= 4, nempty)
      end
      wr(`RFQ_OFS_DATA, 8'haa);
      `CHK("overflow", 1'b1, ovf)
      `CHK("count full", 7'h40, cnt)
      rchk(`RFQ_OFS_DATA, 8'h01);
      rchk(`RFQ_OFS_DATA, 8'h02);
      rchk(`RFQ_OFS_LEVEL, 8'h3e);
      wr(`RFQ_OFS_LEVEL, 8'h80);
      `CHK("overflow flushed", 1'b0, ovf)
      rchk(`RFQ_OFS_LEVEL, 8'h00);
      rchk(`RFQ_OFS_DATA, 8'h00);
      push_n = 4'h4;
      repeat (20) @(negedge sys_clk);
      `CHK("engine count", 7'h04, cnt)
      `CHK("push ready", 1'b1, push_ready)
      pop_en = 1'b1;
      repeat (20) @(negedge sys_clk);
      `CHK("engine order", 32'h13121110, got)
      `CHK("drained", 7'h00, cnt)
      alarm = 1'b1;
      repeat (4) @(negedge sys_clk);
      wr(`RFQ_OFS_STATUS, 8'h80);
      `CHK("overtemp held", 1'b1, oterr)
      alarm = 1'b0;
      repeat (3) @(negedge sys_clk);
      wr(`RFQ_OFS_STATUS, 8'h80);
      `CHK("overtemp cleared", 1'b0, oterr)
      @(negedge sys_clk);
      auth = 1'b1;
      @(negedge sys_clk);
      auth = 1'b0;
      rchk(`RFQ_OFS_STATUS, 8'h88);
      `CHK("cipher on", 1'b1, ciph)
      wr(`RFQ_OFS_STATUS, 8'h40);
      `CHK("cipher cleared", 1'b0, ciph)
      rchk(`RFQ_OFS_STATUS, 8'h40);
      `CHK("forced filter", 1'b1, fsel)
      wr(`RFQ_OFS_STATUS, 8'h00);
      `CHK("protocol filter", 1'b0, fsel)
      proto = 1'b1;
      @(negedge sys_clk);
      `CHK("protocol high speed", 1'b1, fsel)
      proto = 1'b0;
      ev(6'h10, `RFQ_LS_WAIT_TRIG);
      ev(6'h08, `RFQ_LS_TX_GUARD);
      repeat (3) @(negedge sys_clk);
      `CHK("tx guard held", `RFQ_LS_TX_GUARD, st)
      @(negedge sys_clk);
      `CHK("transmitting", `RFQ_LS_TX, st)
      wfield = 1'b1;
      ev(6'h04, `RFQ_LS_RX_GUARD);
      repeat (4) @(negedge sys_clk);
      `CHK("rx guard field", `RFQ_LS_RX_GUARD, st)
      field = 1'b1;
      repeat (4) @(negedge sys_clk);
      `CHK("wait data", `RFQ_LS_WAIT_DATA, st)
      ev(6'h02, `RFQ_LS_RX);
      ev(6'h01, `RFQ_LS_IDLE);
      ev(6'h10, `RFQ_LS_WAIT_TRIG);
      ev(6'h20, `RFQ_LS_IDLE);
      conclude();
   end
endmodule
